//--- dv/brake_model.sv
// Purpose: motor holding brake behind the brake release terminal
// Assumes: the shoe follows the coil after a short contact delay
// Notes: brakeHeld is high while the shoe grips the shaft
`timescale 1ns/10ps
module brake_model #(
  parameter int CONTACT_CYCLES = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic brakeReleaseOutput, // coil powered when high
  output logic brakeHeld // shaft gripped
);
  int contact_q;
  // shoe moves only once the coil level has been steady for the contact delay
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      contact_q <= 0;
      brakeHeld <= 1'b1;
    end else if (brakeHeld == brakeReleaseOutput) begin
      contact_q <= contact_q + 1;
      if (contact_q >= CONTACT_CYCLES) begin
        brakeHeld <= !brakeReleaseOutput;
        contact_q <= 0;
      end
    end else begin
      contact_q <= 0;
    end
  end
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench of the servo brake sequencer
// Assumes: MS_CYCLES of 10, so one ms is ten clocks
// Notes: apb master holds each request until pready
`timescale 1ns/10ps
module tb_top;
  import brake_pkg::*;
  localparam int MS = 10;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic powerCycle = 1'b0;
  logic fourthInputChannel = 1'b1;
  logic driveFault = 1'b0;
  logic [15:0] motorSpeed = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, brakeReleaseOutput, motorEnergized, instrAccept, input4Active, brakeHeld;
  logic [4:0] input4Fn;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int compares = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} row_s;
  row_s rows [18];
  logic [15:0] codes [6] = '{16'h0011, 16'h0012, 16'h0018, 16'h0019, 16'h0001, 16'h0000};
  logic [4:0] fnExp [6] = '{5'h11, 5'h00, 5'h18, 5'h00, 5'h01, 5'h00};

  // clock of 20 ns
  always #10 clk_sys = ~clk_sys;

  servo_brake_sequencer #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerCycle(powerCycle),
    .fourthInputChannel(fourthInputChannel), .driveFault(driveFault), .motorSpeed(motorSpeed),
    .brakeReleaseOutput(brakeReleaseOutput), .motorEnergized(motorEnergized),
    .instrAccept(instrAccept), .input4Active(input4Active), .input4Fn(input4Fn));
  brake_model brake (.clk_sys(clk_sys), .reset(reset), .brakeReleaseOutput(brakeReleaseOutput),
    .brakeHeld(brakeHeld));

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic servo(input logic on, input logic virt);
    apb(1'b1, OFS_CTRL, {30'h0, on, virt});
  endtask

  task automatic power();
    @(posedge clk_sys);
    powerCycle <= 1'b1;
    @(posedge clk_sys);
    powerCycle <= 1'b0;
  endtask

  // run limit
  initial begin
    cyc(100000);
    n_errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    rows = '{'{0, OFS_FN_SEL, 0, 32'h4, 0}, '{0, OFS_POL_SEL, 0, 32'h0, 0}, '{0, OFS_SRC_SEL, 0, 32'h0, 0},
      '{0, OFS_ACCEPT, 0, 32'hFA, 0}, '{0, OFS_STATIC, 0, 32'h96, 0}, '{0, OFS_THRESH, 0, 32'h1E, 0},
      '{0, OFS_ROTDLY, 0, 32'h1F4, 0}, '{0, OFS_CTRL, 0, 32'h0, 0}, '{0, OFS_DO_FN, 0, 32'h0, 0},
      '{0, 8'h40, 0, 32'h0, 1}, '{1, OFS_ACCEPT, 32'h3, 0, 0}, '{1, OFS_STATIC, 32'h4, 0, 0},
      '{1, OFS_ROTDLY, 32'h5, 0, 0}, '{1, OFS_DO_FN, 32'h90, 0, 0}, '{1, 8'h44, 32'h5, 0, 1},
      '{0, OFS_ACCEPT, 0, 32'h3, 0}, '{0, OFS_DO_FN, 0, 32'h90, 0}, '{0, OFS_STATUS, 0, 32'h400, 0}};
    cyc(6);
    reset <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(err, rows[i].x);
      if (!rows[i].w && !rows[i].x) chk(rd, rows[i].e);
    end
    $display("register rows done");
    // brake code written but not yet loaded, delays ignored
    servo(1'b1, 1'b0);
    cyc(4);
    chk(brakeReleaseOutput, 0);
    chk(instrAccept, 1);
    servo(1'b0, 1'b0);
    cyc(3);
    chk(motorEnergized, 0);
    power();
    cyc(2);
    chk(input4Fn, 4);
    servo(1'b1, 1'b0);
    cyc(2 * MS);
    chk(instrAccept, 0);
    cyc(2 * MS);
    chk(instrAccept, 1);
    chk(brakeHeld, 0);
    $display("release test done");
    // static stop at 19 rpm
    motorSpeed <= 16'h0013;
    servo(1'b0, 1'b0);
    cyc(2);
    chk({brakeReleaseOutput, motorEnergized}, 2'b01);
    cyc(3 * MS);
    chk(motorEnergized, 1);
    cyc(2 * MS);
    chk(motorEnergized, 0);
    chk(brakeHeld, 1);
    $display("static test done");
    // rotating stop by threshold
    servo(1'b1, 1'b0);
    cyc(5 * MS);
    motorSpeed <= 16'h0064;
    servo(1'b0, 1'b0);
    cyc(3 * MS);
    chk(brakeReleaseOutput, 1);
    motorSpeed <= 16'h001E;
    cyc(3);
    chk({brakeReleaseOutput, motorEnergized}, 2'b01);
    cyc(45 * MS);
    chk(motorEnergized, 1);
    cyc(7 * MS);
    chk(motorEnergized, 0);
    // rotating stop by delay, 20 rpm is rotating
    apb(1'b1, OFS_THRESH, 32'hA);
    servo(1'b1, 1'b0);
    cyc(5 * MS);
    motorSpeed <= 16'h0014;
    servo(1'b0, 1'b0);
    cyc(4 * MS);
    chk(brakeReleaseOutput, 1);
    cyc(2 * MS);
    chk(brakeReleaseOutput, 0);
    cyc(55 * MS);
    $display("rotating tests done");
    // fault in run coasts
    servo(1'b1, 1'b0);
    cyc(3);
    driveFault <= 1'b1;
    cyc(3);
    chk({brakeReleaseOutput, motorEnergized, instrAccept}, 3'b000);
    servo(1'b0, 1'b0);
    driveFault <= 1'b0;
    cyc(3);
    chk(motorEnergized, 0);
    $display("fault test done");
    // channel polarity and source
    apb(1'b1, OFS_SRC_SEL, 32'h1);
    apb(1'b1, OFS_POL_SEL, 32'h1);
    servo(1'b0, 1'b1);
    cyc(3);
    chk(input4Active, 1);
    servo(1'b0, 1'b0);
    cyc(3);
    chk(input4Active, 0);
    apb(1'b1, OFS_POL_SEL, 32'h0);
    cyc(3);
    chk(input4Active, 1);
    apb(1'b1, OFS_SRC_SEL, 32'h0);
    cyc(3);
    chk(input4Active, 0);
    fourthInputChannel <= 1'b0;
    cyc(3);
    chk(input4Active, 1);
    apb(1'b1, OFS_FN_SEL, 32'h5);
    cyc(2);
    chk(input4Fn, 4);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_FN_SEL, {16'h0, codes[i]});
      power();
      cyc(3);
      chk(input4Fn, fnExp[i]);
      // code 1 makes the active channel a servo enable; dropping it then starts a rotating stop
      chk(motorEnergized, i >= 4);
    end
    chk(input4Active, 0);
    $display("channel tests done");
    // second reset in mid-run
    reset <= 1'b1;
    cyc(2);
    chk({brakeReleaseOutput, motorEnergized, instrAccept}, 3'b000);
    reset <= 1'b0;
    apb(1'b0, OFS_ACCEPT, 32'h0);
    chk(rd, 32'hFA);
    $display("reset test done");
    report_and_stop();
  end
endmodule

//--- rtl/brake_pkg.sv
// Purpose: shared constants of the servo brake sequencer
// Assumes: 50 MHz system clock, APB with 32-bit data
// Notes: speeds in rpm, delays in milliseconds
package brake_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FN_SEL = 8'h00;
  localparam logic [7:0] OFS_POL_SEL = 8'h04;
  localparam logic [7:0] OFS_SRC_SEL = 8'h08;
  localparam logic [7:0] OFS_ACCEPT = 8'h0C;
  localparam logic [7:0] OFS_STATIC = 8'h10;
  localparam logic [7:0] OFS_THRESH = 8'h14;
  localparam logic [7:0] OFS_ROTDLY = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1C;
  localparam logic [7:0] OFS_DO_FN = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // reset values
  localparam logic [15:0] RST_FN_SEL = 16'h0004;
  localparam logic [15:0] RST_POL_SEL = 16'h0000;
  localparam logic [15:0] RST_SRC_SEL = 16'h0000;
  localparam logic [15:0] RST_ACCEPT = 16'h00FA;
  localparam logic [15:0] RST_STATIC = 16'h0096;
  localparam logic [15:0] RST_THRESH = 16'h001E;
  localparam logic [15:0] RST_ROTDLY = 16'h01F4;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_DO_FN = 16'h0000;
  // control register fields
  localparam int CTRL_VIRT_BIT = 0;
  localparam int CTRL_SERVO_BIT = 1;
  // input channel function codes
  localparam logic [15:0] FN_UNUSED = 16'h0000;
  localparam logic [15:0] FN_SERVO_ON = 16'h0001;
  localparam logic [15:0] FN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_FWD_INHIBIT = 16'h0003;
  localparam logic [15:0] FN_REV_INHIBIT = 16'h0004;
  localparam logic [15:0] FN_LAST_LOW = 16'h0011;
  localparam logic [15:0] FN_FIRST_HIGH = 16'h0014;
  localparam logic [15:0] FN_LAST = 16'h0018;
  // output function code of the brake-release terminal
  localparam logic [15:0] DO_FN_BRAKE = 16'h0090;
  // speed classification and fixed hold time
  localparam logic [15:0] STATIC_SPEED_RPM = 16'h0014;
  localparam logic [15:0] ROT_HOLD_MS = 16'h0032;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RUN = 6'b000010,
    ST_STATIC = 6'b000100,
    ST_ROT_WAIT = 6'b001000,
    ST_ROT_HOLD = 6'b010000,
    ST_FAULT = 6'b100000
  } brake_state_e;
endpackage

//--- rtl/ms_delay_timer.sv
// Purpose: millisecond delay timer with restart
// Assumes: TICK_CYCLES clock cycles make one millisecond
// Notes: done is a level, high once limit milliseconds have passed
`timescale 1ns/10ps
module ms_delay_timer #(
  parameter int TICK_CYCLES = 50000
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic restart, // one-cycle pulse, starts a new interval
  input wire logic [15:0] limit, // interval length in ms
  output logic done // interval elapsed
);
  logic [31:0] preQ;
  logic [15:0] msQ;
  logic tick;

  // prescaler restarts with the interval so the first ms is whole
  assign tick = (preQ == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (reset || restart || tick) begin
      preQ <= 32'h0000_0000;
    end else begin
      preQ <= preQ + 32'h0000_0001;
    end
  end

  // millisecond count saturates so done stays up
  always_ff @(posedge clk_sys) begin
    if (reset || restart) begin
      msQ <= 16'h0000;
    end else if (tick && msQ != 16'hFFFF) begin
      msQ <= msQ + 16'h0001;
    end
  end

  // not gated by restart: restart is derived from done, so a gate would close a combinational loop
  assign done = (msQ >= limit);
endmodule

//--- rtl/servo_brake_sequencer.sv
// Purpose: brake sequencing and fourth input channel mapping of a servo drive
// Assumes: motorSpeed is absolute speed in rpm, synchronous to clk_sys
// Notes: APB slave, zero wait states; config copies load on powerCycle
// Function
// - input4 function 0 unused, 1..17 and 20..24 functions, rest reserved; default 4, power-cycle
// - input4 polarity 0 active low, 1 active high; applies at once
// - input4 source 0 physical terminal, 1 virtual bit; applies at once
// - any drive fault gives free-coast shutdown, nothing else
// - output function code 144 makes the terminal the brake release; power-cycle
// - instructions refused for accept delay after brake release goes on
// - static: stay energized static delay after brake off, then de-energize
// - rotating: brake off allowed once speed falls to threshold
// - rotating: brake off allowed once rotating delay from servo off elapsed
// - without brake terminal all four brake parameters are ignored
// - below 20 rpm static, 20 rpm or more rotating
// - servo off below 20 rpm runs static sequence
// - static sequence: brake off at once, energized during static delay
// - rotating: brake off on threshold reached or delay expired
// - rotating: energized 50 ms after brake goes off
`timescale 1ns/10ps
module servo_brake_sequencer
  import brake_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic powerCycle, // pulse, loads power-cycle settings
  input wire logic fourthInputChannel, // physical input terminal
  input wire logic driveFault, // any drive fault, level
  input wire logic [15:0] motorSpeed, // actual speed in rpm
  output logic brakeReleaseOutput, // brake release terminal
  output logic motorEnergized, // motor powered
  output logic instrAccept, // motion instructions accepted
  output logic input4Active, // fourth channel asserted
  output logic [4:0] input4Fn // active function of fourth channel
);
  logic [15:0] fnSelQ, polSelQ, srcSelQ, acceptQ, staticQ, threshQ, rotDlyQ, ctrlQ, doFnQ;
  logic [15:0] fnActQ, doFnActQ;
  logic [31:0] rdData;
  logic mapped, wrEn;
  brake_state_e stateQ, stateD;
  logic brakeAssigned, rotating, servoEn, rawIn, chanActive;
  logic timerDone, restart;
  logic [15:0] limit;

  // keep only documented function codes, reserved values read as unused
  function automatic logic [15:0] validFn(input logic [15:0] code);
    if (code <= FN_LAST_LOW || (code >= FN_FIRST_HIGH && code <= FN_LAST)) begin
      return code;
    end
    return FN_UNUSED;
  endfunction

  // address decode
  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    unique case (paddr)
      OFS_FN_SEL: rdData = {16'h0000, fnSelQ};
      OFS_POL_SEL: rdData = {16'h0000, polSelQ};
      OFS_SRC_SEL: rdData = {16'h0000, srcSelQ};
      OFS_ACCEPT: rdData = {16'h0000, acceptQ};
      OFS_STATIC: rdData = {16'h0000, staticQ};
      OFS_THRESH: rdData = {16'h0000, threshQ};
      OFS_ROTDLY: rdData = {16'h0000, rotDlyQ};
      OFS_CTRL: rdData = {16'h0000, ctrlQ};
      OFS_DO_FN: rdData = {16'h0000, doFnQ};
      OFS_STATUS: rdData = {16'h0000, fnActQ[7:0], brakeAssigned, rotating, servoEn,
                            chanActive, instrAccept, motorEnergized, brakeReleaseOutput,
                            stateQ == ST_FAULT};
      default: mapped = 1'b0;
    endcase
  end

  assign wrEn = psel && penable && pready && pwrite && mapped;

  // apb answer, ready one cycle after setup
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // writable registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fnSelQ <= RST_FN_SEL;
      polSelQ <= RST_POL_SEL;
      srcSelQ <= RST_SRC_SEL;
      acceptQ <= RST_ACCEPT;
      staticQ <= RST_STATIC;
      threshQ <= RST_THRESH;
      rotDlyQ <= RST_ROTDLY;
      ctrlQ <= RST_CTRL;
      doFnQ <= RST_DO_FN;
    end else if (wrEn) begin
      unique case (paddr)
        OFS_FN_SEL: fnSelQ <= pwdata[15:0];
        OFS_POL_SEL: polSelQ <= pwdata[15:0];
        OFS_SRC_SEL: srcSelQ <= pwdata[15:0];
        OFS_ACCEPT: acceptQ <= pwdata[15:0];
        OFS_STATIC: staticQ <= pwdata[15:0];
        OFS_THRESH: threshQ <= pwdata[15:0];
        OFS_ROTDLY: rotDlyQ <= pwdata[15:0];
        OFS_CTRL: ctrlQ <= pwdata[15:0];
        OFS_DO_FN: doFnQ <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // settings that act only after power cycling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fnActQ <= RST_FN_SEL;
      doFnActQ <= RST_DO_FN;
    end else if (powerCycle) begin
      fnActQ <= validFn(fnSelQ);
      doFnActQ <= doFnQ;
    end
  end

  // fourth channel: source and polarity act at once
  assign rawIn = srcSelQ[0] ? ctrlQ[CTRL_VIRT_BIT] : fourthInputChannel;
  assign chanActive = polSelQ[0] ? rawIn : !rawIn;
  assign servoEn = ctrlQ[CTRL_SERVO_BIT] || (fnActQ == FN_SERVO_ON && chanActive);
  assign brakeAssigned = (doFnActQ == DO_FN_BRAKE);
  assign rotating = (motorSpeed >= STATIC_SPEED_RPM);

  // channel outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      input4Active <= 1'b0;
      input4Fn <= 5'h00;
    end else begin
      input4Active <= chanActive && fnActQ != FN_UNUSED;
      input4Fn <= 5'(validFn(fnActQ));
    end
  end

  // next state of the brake sequence
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_IDLE: begin
        if (servoEn) begin
          stateD = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!servoEn) begin
          if (!brakeAssigned) begin
            stateD = ST_IDLE;
          end else if (rotating) begin
            stateD = ST_ROT_WAIT;
          end else begin
            stateD = ST_STATIC;
          end
        end
      end
      ST_STATIC: begin
        if (timerDone) begin
          stateD = ST_IDLE;
        end
      end
      ST_ROT_WAIT: begin
        if (motorSpeed <= threshQ || timerDone) begin
          stateD = ST_ROT_HOLD;
        end
      end
      ST_ROT_HOLD: begin
        if (timerDone) begin
          stateD = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (!servoEn) begin
          stateD = ST_IDLE;
        end
      end
      default: stateD = ST_FAULT;
    endcase
    if (driveFault) begin
      stateD = ST_FAULT;
    end
  end

  // interval length per state
  always_comb begin
    unique case (stateQ)
      ST_RUN: limit = brakeAssigned ? acceptQ : 16'h0000;
      ST_STATIC: limit = staticQ;
      ST_ROT_WAIT: limit = rotDlyQ;
      ST_ROT_HOLD: limit = ROT_HOLD_MS;
      default: limit = 16'h0000;
    endcase
  end

  assign restart = (stateD != stateQ);

  ms_delay_timer #(
    .TICK_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .restart(restart),
    .limit(limit),
    .done(timerDone)
  );

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // terminal outputs follow the next state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brakeReleaseOutput <= 1'b0;
      motorEnergized <= 1'b0;
      instrAccept <= 1'b0;
    end else begin
      brakeReleaseOutput <= brakeAssigned && (stateD == ST_RUN || stateD == ST_ROT_WAIT);
      motorEnergized <= stateD inside {ST_RUN, ST_STATIC, ST_ROT_WAIT, ST_ROT_HOLD};
      instrAccept <= stateD == ST_RUN && stateQ == ST_RUN && timerDone;
    end
  end

  // cycles since the last state change, kept apart from the timer for the interval checks
  logic [31:0] seqCntQ;
  always_ff @(posedge clk_sys) begin
    if (reset || restart) begin
      seqCntQ <= 32'h0000_0000;
    end else if (seqCntQ != 32'hFFFF_FFFF) begin
      seqCntQ <= seqCntQ + 32'h0000_0001;
    end
  end

  // checks
  a_fault_coast: assert property (@(posedge clk_sys) disable iff (reset)
    driveFault |=> !motorEnergized && !brakeReleaseOutput && !instrAccept)
    else $error("fault did not coast");
  a_accept_hold: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(brakeReleaseOutput) |-> !instrAccept ##1 (!instrAccept || acceptQ <= 16'h0001))
    else $error("instruction accepted before delay");
  a_accept_open: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_RUN && timerDone && servoEn && !driveFault |=> instrAccept)
    else $error("instructions still refused after delay");
  a_static_drop: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_RUN && !servoEn && !rotating && brakeAssigned && !driveFault
    |=> !brakeReleaseOutput && motorEnergized && stateQ == ST_STATIC)
    else $error("static sequence not entered");
  a_static_end: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_STATIC && timerDone |=> !motorEnergized)
    else $error("motor energized past static delay");
  a_speed_class: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_RUN && !servoEn && rotating && brakeAssigned && !driveFault
    |=> stateQ == ST_ROT_WAIT && brakeReleaseOutput == 1'b1 && motorEnergized)
    else $error("rotating sequence not entered");
  a_rot_thresh: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_ROT_WAIT && !driveFault && motorSpeed <= threshQ |=> stateQ == ST_ROT_HOLD)
    else $error("threshold did not end wait");
  a_rot_delay: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_ROT_WAIT && !driveFault && timerDone |=> stateQ == ST_ROT_HOLD)
    else $error("rotating delay did not end wait");
  a_rot_hold: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(stateQ == ST_ROT_HOLD) && !driveFault |-> motorEnergized [*2])
    else $error("energy dropped inside hold");
  a_no_brake: assert property (@(posedge clk_sys) disable iff (reset)
    !brakeAssigned |-> !brakeReleaseOutput ##1 (stateQ != ST_STATIC && stateQ != ST_ROT_WAIT))
    else $error("brake sequence without brake terminal");
  a_chan_map: assert property (@(posedge clk_sys) disable iff (reset)
    fnActQ != FN_UNUSED && !srcSelQ[0]
    |=> input4Active == ($past(fourthInputChannel) == $past(polSelQ[0])))
    else $error("input channel mapping wrong");
  a_chan_virt: assert property (@(posedge clk_sys) disable iff (reset)
    fnActQ != FN_UNUSED && srcSelQ[0]
    |=> input4Active == ($past(ctrlQ[CTRL_VIRT_BIT]) == $past(polSelQ[0])))
    else $error("virtual input mapping wrong");
  a_pol_now: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(polSelQ[0]) && $stable(rawIn) && $stable(fnActQ) && fnActQ != FN_UNUSED
    |=> $changed(input4Active))
    else $error("polarity change did not act at once");
  a_unused_off: assert property (@(posedge clk_sys) disable iff (reset)
    fnActQ == FN_UNUSED |=> !input4Active)
    else $error("unused channel reported active");

  // power-cycle settings move only on the load pulse
  a_fn_stable: assert property (@(posedge clk_sys) disable iff (reset)
    !powerCycle |=> $stable(fnActQ) && $stable(doFnActQ))
    else $error("active settings changed without power cycle");
  a_fn_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    input4Fn <= FN_LAST[4:0] && !(input4Fn > FN_LAST_LOW[4:0] && input4Fn < FN_FIRST_HIGH[4:0]))
    else $error("reserved function code reported");
  a_brake_code: assert property (@(posedge clk_sys) disable iff (reset)
    brakeReleaseOutput |-> $past(doFnActQ) == DO_FN_BRAKE)
    else $error("brake released without brake terminal code");

  // brake terminal level per sequence state
  a_rot_brake_on: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_ROT_WAIT && $past(brakeAssigned) |-> brakeReleaseOutput)
    else $error("brake applied before rotating stop condition");
  a_static_brake: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_STATIC |-> !brakeReleaseOutput)
    else $error("brake released in static sequence");
  a_fault_state: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_FAULT |-> !motorEnergized && !brakeReleaseOutput && !instrAccept)
    else $error("outputs active in fault state");

  // interval lengths against the independent cycle count
  a_accept_len: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_RUN && brakeAssigned && seqCntQ < 32'(acceptQ) * 32'(MS_CYCLES) |=> !instrAccept)
    else $error("instructions accepted inside accept delay");
  a_static_hold: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_STATIC && !driveFault && seqCntQ < 32'(staticQ) * 32'(MS_CYCLES)
    |=> motorEnergized)
    else $error("energy dropped inside static delay");
  a_rot_hold_len: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_ROT_HOLD && !driveFault && seqCntQ < 32'(ROT_HOLD_MS) * 32'(MS_CYCLES)
    |=> motorEnergized)
    else $error("energy dropped inside rotating hold");
  a_rot_hold_end: assert property (@(posedge clk_sys) disable iff (reset)
    stateQ == ST_ROT_HOLD && seqCntQ == 32'(ROT_HOLD_MS) * 32'(MS_CYCLES) |=> !motorEnergized)
    else $error("motor energized past rotating hold");
endmodule
